// ==== rtl/dscp_remap_pkg.sv ====
// Constants shared by the DSCP priority remap table files.
package dscp_remap_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W  = 16;
	localparam int DATA_W  = 8;
	localparam int PRIO_W  = 3;
	localparam int DSCP_W  = 6;
	localparam int ENTRY_N = 15;
	localparam int IDX_W   = 4;
	localparam int PAIR_W  = 2 * PRIO_W;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] DSCP_MAP_04_05 = 16'h0342;
	localparam logic [ADDR_W-1:0] DSCP_MAP_06_07 = 16'h0343;
	localparam logic [ADDR_W-1:0] DSCP_MAP_08_09 = 16'h0344;
	localparam logic [ADDR_W-1:0] DSCP_MAP_0A_0B = 16'h0345;
	localparam logic [ADDR_W-1:0] DSCP_MAP_0C_0D = 16'h0346;
	localparam logic [ADDR_W-1:0] DSCP_MAP_0E_0F = 16'h0347;
	localparam logic [ADDR_W-1:0] DSCP_MAP_10_11 = 16'h0348;
	localparam logic [ADDR_W-1:0] DSCP_MAP_12_13 = 16'h0349;
	localparam logic [ADDR_W-1:0] DSCP_MAP_14_15 = 16'h034a;
	localparam logic [ADDR_W-1:0] DSCP_MAP_16_17 = 16'h034b;
	localparam logic [ADDR_W-1:0] DSCP_MAP_18_19 = 16'h034c;
	localparam logic [ADDR_W-1:0] DSCP_MAP_1A_1B = 16'h034d;
	localparam logic [ADDR_W-1:0] DSCP_MAP_1C_1D = 16'h034e;
	localparam logic [ADDR_W-1:0] DSCP_MAP_1E_1F = 16'h034f;
	localparam logic [ADDR_W-1:0] DSCP_MAP_20_21 = 16'h0350;

	// ------------------------------------------------------------
	// Field layout and values
	// ------------------------------------------------------------
	localparam int LO_LSB     = 0;
	localparam int HI_LSB     = 4;
	localparam int DIRECT_LSB = 3;

	localparam logic [PRIO_W-1:0] PRIO_RESET   = 3'h0;
	localparam logic [PRIO_W-1:0] PRIO_NONE    = 3'h0;
	localparam logic [DATA_W-1:0] RDATA_IDLE   = 8'h00;
	localparam logic [DSCP_W-1:0] DSCP_FIRST   = 6'h04;
	localparam logic [DSCP_W-1:0] DSCP_LAST    = 6'h21;

	// ------------------------------------------------------------
	// Source of the priority handed on
	// ------------------------------------------------------------
	typedef enum logic [3:0]
	{
		SRC_NONE   = 4'b0001,
		SRC_TABLE  = 4'b0010,
		SRC_DIRECT = 4'b0100,
		SRC_EXT    = 4'b1000
	} prio_src_e;

endpackage

// ==== rtl/dscp_map_index.sv ====
// Address and DSCP decode into table entry indices.
`timescale 1ns/1ps

module dscp_map_index
(
	// Register address
	input  wire logic [15:0] addr_i,
	output logic             addr_hit_o,
	output logic [3:0]       addr_idx_o,
	// DSCP code
	input  wire logic [5:0]  dscp_i,
	output logic             dscp_hit_o,
	output logic [3:0]       dscp_idx_o,
	output logic             dscp_odd_o
);

	logic [15:0] addr_off;
	logic [5:0]  dscp_off;

	// The entries are contiguous, so the offset from the first one is the index.
	assign addr_off   = addr_i - dscp_remap_pkg::DSCP_MAP_04_05;
	assign addr_hit_o = (addr_i >= dscp_remap_pkg::DSCP_MAP_04_05)
	                  && (addr_i <= dscp_remap_pkg::DSCP_MAP_20_21);
	assign addr_idx_o = addr_off[3:0];

	// Two codes share one entry; the odd code takes the high field.
	assign dscp_off   = dscp_i - dscp_remap_pkg::DSCP_FIRST;
	assign dscp_hit_o = (dscp_i >= dscp_remap_pkg::DSCP_FIRST)
	                  && (dscp_i <= dscp_remap_pkg::DSCP_LAST);
	assign dscp_idx_o = dscp_off[4:1];
	assign dscp_odd_o = dscp_i[0];

endmodule

// ==== rtl/dscp_map_store.sv ====
// Storage of the priority entry pairs with registered read ports.
`timescale 1ns/1ps

module dscp_map_store
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// Write port
	input  wire logic       wr_en_i,
	input  wire logic [3:0] wr_idx_i,
	input  wire logic [5:0] wr_data_i,
	// Bus read port
	input  wire logic       bus_en_i,
	input  wire logic [3:0] bus_idx_i,
	output logic      [5:0] bus_data_o,
	// Lookup read port
	input  wire logic [3:0] lk_idx_i,
	output logic      [5:0] lk_data_o
);

	logic [5:0] entry_r [dscp_remap_pkg::ENTRY_N];

	// ------------------------------------------------------------
	// Entries
	// ------------------------------------------------------------
	for (genvar g = 0; g < dscp_remap_pkg::ENTRY_N; g++)
	begin : g_entry
		always_ff @(posedge clk_i)
		begin
			if (reset_i)
				entry_r[g] <= {dscp_remap_pkg::PRIO_RESET, dscp_remap_pkg::PRIO_RESET};
			else if (wr_en_i && (wr_idx_i == 4'(g)))
				entry_r[g] <= wr_data_i;
		end
	end

	// ------------------------------------------------------------
	// Read ports
	// ------------------------------------------------------------
	// Bus data rest at zero so the read answer stands for one cycle only.
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !bus_en_i)
			bus_data_o <= {dscp_remap_pkg::PRIO_RESET, dscp_remap_pkg::PRIO_RESET};
		else
			bus_data_o <= entry_r[bus_idx_i];
	end

	// Write-first, so a frame taken with a write to its entry sees the new value.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			lk_data_o <= {dscp_remap_pkg::PRIO_RESET, dscp_remap_pkg::PRIO_RESET};
		else if (wr_en_i && (wr_idx_i == lk_idx_i))
			lk_data_o <= wr_data_i;
		else
			lk_data_o <= entry_r[lk_idx_i];
	end

endmodule

// ==== rtl/dscp_priority_remap_table.sv ====
// DSCP to internal priority remap table for codes 0x04 to 0x21.
//
// Behaviour
// - IP frames get 3-bit priority by DSCP.
// - Codes 0x04-0x0F from 0x0342-0x0347.
// - Codes 0x10-0x1F from 0x0348-0x034F.
// - Codes 0x20, 0x21 from 0x0350.
// - Entries reset to zero, readable and writable.
// - Remap disabled: priority is DSCP bits 5:3.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module dscp_priority_remap_table
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// Register port
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// Frame classification request
	input  wire logic        frame_valid_i,
	input  wire logic        frame_ip_i,
	input  wire logic [5:0]  dscp_i,
	input  wire logic        remap_en_i,
	input  wire logic [2:0]  ext_prio_i,
	// Classification answer
	output logic             prio_valid_o,
	output logic      [2:0]  prio_o,
	output logic      [3:0]  prio_src_o
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic       addr_hit;
	logic [3:0] addr_idx;
	logic       dscp_hit;
	logic [3:0] dscp_idx;
	logic       dscp_odd;

	dscp_map_index u_index
	(
		.addr_i     (addr_i),
		.addr_hit_o (addr_hit),
		.addr_idx_o (addr_idx),
		.dscp_i     (dscp_i),
		.dscp_hit_o (dscp_hit),
		.dscp_idx_o (dscp_idx),
		.dscp_odd_o (dscp_odd)
	);

	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	logic       map_wr;
	logic       map_rd;
	logic [5:0] map_wdata;
	logic [5:0] bus_pair;
	logic [5:0] lk_pair;

	// Writes and reads outside the table range are ignored and read as zero.
	assign map_wr = wr_i && addr_hit;
	assign map_rd = rd_i && addr_hit;

	// Bits 7 and 3 are dropped on the way in.
	assign map_wdata =
	{
		wdata_i[dscp_remap_pkg::HI_LSB +: dscp_remap_pkg::PRIO_W],
		wdata_i[dscp_remap_pkg::LO_LSB +: dscp_remap_pkg::PRIO_W]
	};

	dscp_map_store u_store
	(
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.wr_en_i    (map_wr),
		.wr_idx_i   (addr_idx),
		.wr_data_i  (map_wdata),
		.bus_en_i   (map_rd),
		.bus_idx_i  (addr_idx),
		.bus_data_o (bus_pair),
		.lk_idx_i   (dscp_idx),
		.lk_data_o  (lk_pair)
	);

	// The read data are wiring of the store's read register, zero when idle.
	assign rdata_o =
	{
		1'b0,
		bus_pair[dscp_remap_pkg::PRIO_W +: dscp_remap_pkg::PRIO_W],
		1'b0,
		bus_pair[0 +: dscp_remap_pkg::PRIO_W]
	};

	// ------------------------------------------------------------
	// Lookup stage one
	// ------------------------------------------------------------
	// The table read takes one cycle, so the frame's attributes wait beside it.
	logic       s1_valid_r;
	logic       s1_ip_r;
	logic       s1_en_r;
	logic       s1_hit_r;
	logic       s1_odd_r;
	logic [2:0] s1_direct_r;
	logic [2:0] s1_ext_r;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			s1_valid_r <= 1'b0;
		else
			s1_valid_r <= frame_valid_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			s1_ip_r     <= 1'b0;
			s1_en_r     <= 1'b0;
			s1_hit_r    <= 1'b0;
			s1_odd_r    <= 1'b0;
			s1_direct_r <= dscp_remap_pkg::PRIO_NONE;
			s1_ext_r    <= dscp_remap_pkg::PRIO_NONE;
		end
		else if (frame_valid_i)
		begin
			s1_ip_r     <= frame_ip_i;
			s1_en_r     <= remap_en_i;
			s1_hit_r    <= dscp_hit;
			s1_odd_r    <= dscp_odd;
			s1_direct_r <= dscp_i[dscp_remap_pkg::DIRECT_LSB +: dscp_remap_pkg::PRIO_W];
			s1_ext_r    <= ext_prio_i;
		end
	end

	// ------------------------------------------------------------
	// Priority selection
	// ------------------------------------------------------------
	logic [2:0]                tbl_prio;
	logic [2:0]                prio_nxt;
	dscp_remap_pkg::prio_src_e src_nxt;

	// Even code in the low field, odd code in the high field.
	assign tbl_prio = s1_odd_r ? lk_pair[dscp_remap_pkg::PRIO_W +: dscp_remap_pkg::PRIO_W]
	                           : lk_pair[0 +: dscp_remap_pkg::PRIO_W];

	always_comb
	begin
		prio_nxt = dscp_remap_pkg::PRIO_NONE;
		src_nxt  = dscp_remap_pkg::SRC_NONE;
		if (!s1_ip_r)
		begin
			prio_nxt = dscp_remap_pkg::PRIO_NONE;
			src_nxt  = dscp_remap_pkg::SRC_NONE;
		end
		else if (!s1_en_r)
		begin
			prio_nxt = s1_direct_r;
			src_nxt  = dscp_remap_pkg::SRC_DIRECT;
		end
		else if (s1_hit_r)
		begin
			prio_nxt = tbl_prio;
			src_nxt  = dscp_remap_pkg::SRC_TABLE;
		end
		else
		begin
			// Codes held by the neighbouring tables arrive on the side input.
			prio_nxt = s1_ext_r;
			src_nxt  = dscp_remap_pkg::SRC_EXT;
		end
	end

	// ------------------------------------------------------------
	// Answer registers
	// ------------------------------------------------------------
	dscp_remap_pkg::prio_src_e src_r;
	logic [2:0]                prio_r;
	logic                      valid_r;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			valid_r <= 1'b0;
		else
			valid_r <= s1_valid_r;
	end

	// Priority and source hold their last value between answers.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			prio_r <= dscp_remap_pkg::PRIO_NONE;
			src_r  <= dscp_remap_pkg::SRC_NONE;
		end
		else if (s1_valid_r)
		begin
			prio_r <= prio_nxt;
			src_r  <= src_nxt;
		end
	end

	assign prio_valid_o = valid_r;
	assign prio_o       = prio_r;
	assign prio_src_o   = src_r;

endmodule

// ==== dv/dscp_remap_chk.sv ====
// Port checker for the DSCP priority remap table.
`timescale 1ns/1ps

module dscp_remap_chk
(
	// Clock, reset and register port
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  rdata_o,
	// Frame lookup
	input wire logic        frame_valid_i,
	input wire logic        frame_ip_i,
	input wire logic [5:0]  dscp_i,
	input wire logic        remap_en_i,
	input wire logic [2:0]  ext_prio_i,
	input wire logic        prio_valid_o,
	input wire logic [2:0]  prio_o,
	input wire logic [3:0]  prio_src_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// Upper three code bits, the priority used while remapping is off.
	logic [2:0] dscp_hi;
	assign dscp_hi = dscp_i[5:3];

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence s_req(logic ip, logic en);
		frame_valid_i && frame_ip_i == ip && remap_en_i == en;
	endsequence

	sequence s_map_wr;
		wr_i && addr_i >= 16'h0342 && addr_i <= 16'h0350;
	endsequence

	property p_wr_rd;
		s_map_wr ##1 (rd_i && addr_i == $past(addr_i))
			|=> rdata_o == ($past(wdata_i, 2) & 8'h77);
	endproperty

	property p_direct;
		s_req(1'b1, 1'b0) |-> ##2 prio_o == $past(dscp_hi, 2) && prio_src_o == 4'b0100;
	endproperty

	chk_read_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata not idle");
	chk_rsvd_bits: assert property (rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0) else $error("rsvd bit");
	chk_write_read: assert property (p_wr_rd) else $error("read back differs from write");
	chk_answer_delay: assert property (frame_valid_i |-> ##2 prio_valid_o) else $error("no answer");
	chk_no_spurious: assert property (!frame_valid_i |-> ##2 !prio_valid_o) else $error("extra answer");
	chk_direct_prio: assert property (p_direct) else $error("direct priority wrong");
	chk_table_src: assert property (s_req(1'b1, 1'b1) ##0 dscp_i >= 6'h04 && dscp_i <= 6'h21
		|-> ##2 prio_src_o == 4'b0010) else $error("table not used");
	chk_prio_hold: assert property (!prio_valid_o |-> $stable(prio_o) && $stable(prio_src_o))
		else $error("priority moved without answer");
endmodule

bind dscp_priority_remap_table dscp_remap_chk u_chk
(
	.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .frame_valid_i(frame_valid_i), .frame_ip_i(frame_ip_i),
	.dscp_i(dscp_i), .remap_en_i(remap_en_i), .ext_prio_i(ext_prio_i),
	.prio_valid_o(prio_valid_o), .prio_o(prio_o), .prio_src_o(prio_src_o)
);

// ==== dv/tb_top.sv ====
// Self-checking bench for the DSCP priority remap table.
`timescale 1ns/1ps

module tb_top;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        frame_valid_i = 1'b0;
	logic        frame_ip_i = 1'b0;
	logic [5:0]  dscp_i = 6'h00;
	logic        remap_en_i = 1'b0;
	logic [2:0]  ext_prio_i = 3'h0;
	logic [7:0]  rdata_o;
	logic        prio_valid_o;
	logic [2:0]  prio_o;
	logic [3:0]  prio_src_o;
	logic [7:0]  img [15];
	int          err_count = 0;
	int          check_count = 0;

	always #25 clk_i = ~clk_i;

	dscp_priority_remap_table dut
	(
		.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .frame_valid_i(frame_valid_i), .frame_ip_i(frame_ip_i),
		.dscp_i(dscp_i), .remap_en_i(remap_en_i), .ext_prio_i(ext_prio_i),
		.prio_valid_o(prio_valid_o), .prio_o(prio_o), .prio_src_o(prio_src_o)
	);

	// ------------------------------------------------------------
	// Bus cycles and comparison
	// ------------------------------------------------------------
	task automatic check(logic [7:0] got, logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// The wr, rd and look tasks start just after a rising edge and return just after one.
	task automatic wr(logic [15:0] a, logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		if (a >= 16'h0342 && a <= 16'h0350)
			img[a - 16'h0342] = d & 8'h77;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(logic [15:0] a, logic [7:0] exp);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		check(rdata_o, exp);
		@(posedge clk_i);
	endtask

	task automatic look(logic ip, logic en, logic [5:0] c, logic [2:0] x, logic [2:0] p,
		logic [3:0] s);
		frame_valid_i <= 1'b1;
		frame_ip_i <= ip;
		remap_en_i <= en;
		dscp_i <= c;
		ext_prio_i <= x;
		@(posedge clk_i);
		frame_valid_i <= 1'b0;
		wr_i <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		check({prio_valid_o, prio_o, prio_src_o}, {1'b1, p, s});
		@(posedge clk_i);
	endtask

	function automatic logic [2:0] tbl(logic [5:0] c);
		logic [7:0] r;
		r = img[(c - 6'h04) >> 1];
		return c[0] ? r[6:4] : r[2:0];
	endfunction

	task automatic do_reset();
		reset_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		foreach (img[k]) img[k] = 8'h00;
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_zero();
		for (int k = 0; k < 15; k++)
			rd(16'h0342 + k, 8'h00);
		look(1'b1, 1'b1, 6'h05, 3'h7, 3'h0, 4'b0010);
		$display("zero test done");
	endtask

	task automatic t_regs();
		for (int k = 0; k < 15; k++)
		begin
			wr(16'h0342 + k, 8'hff - 8'(8'h11 * k));
			rd(16'h0342 + k, img[k]);
		end
		wr(16'h0341, 8'hff);
		rd(16'h0341, 8'h00);
		wr(16'h0351, 8'hff);
		rd(16'h0351, 8'h00);
		$display("register test done");
	endtask

	task automatic t_table();
		for (int c = 4; c <= 33; c++)
			look(1'b1, 1'b1, 6'(c), ~tbl(6'(c)), tbl(6'(c)), 4'b0010);
		look(1'b1, 1'b1, 6'h03, 3'h6, 3'h6, 4'b1000);
		look(1'b1, 1'b1, 6'h22, 3'h5, 3'h5, 4'b1000);
		look(1'b1, 1'b0, 6'h2d, 3'h0, 3'h5, 4'b0100);
		look(1'b1, 1'b0, 6'h07, 3'h6, 3'h0, 4'b0100);
		look(1'b0, 1'b1, 6'h05, 3'h7, 3'h0, 4'b0001);
		$display("lookup test done");
	endtask

	task automatic t_rewrite();
		wr(16'h0350, 8'h3a);
		look(1'b1, 1'b1, 6'h21, 3'h0, 3'h3, 4'b0010);
		look(1'b1, 1'b1, 6'h20, 3'h0, 3'h2, 4'b0010);
		// A write in the cycle of the request must already reach that frame.
		addr_i <= 16'h0342;
		wdata_i <= 8'hd5;
		wr_i <= 1'b1;
		img[0] = 8'h55;
		look(1'b1, 1'b1, 6'h05, 3'h0, 3'h5, 4'b0010);
		rd(16'h0342, 8'h55);
		$display("rewrite test done");
	endtask

	initial
	begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		stop_test();
	end

	initial
	begin
		do_reset();
		t_zero();
		t_regs();
		t_table();
		t_rewrite();
		do_reset();
		t_zero();
		stop_test();
	end
endmodule
